// ===== src/lvwrc_pkg.sv
// constants, types and layouts of the low-voltage wake and reset control block
//
// Behaviour
// - no wake, no interrupt: detection cannot wake
// - running, interrupt disabled: detection changes nothing
// - asleep, interrupt only: set flag, stay asleep
// - asleep, wake only: wake, next instruction, no flag
// - global disable: set flag, next instruction, wake
// - global enable: set flag, vector 021H, wake
// - sleep stops oscillator and timers; idle runs timers
// - power-on loads documented values; port5/6 directions kept otherwise, port7 direction reloaded
package lvwrc_pkg;

  // --------------------------------------------------------------
  // power modes
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    LVWRC_NORMAL = 2'b00,
    LVWRC_GREEN  = 2'b01,
    LVWRC_IDLE   = 2'b10,
    LVWRC_SLEEP  = 2'b11
  } lvwrc_mode_e;

  // --------------------------------------------------------------
  // register byte addresses
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT5_DIR  = 8'h00;
  localparam logic [7:0] ADDR_PORT6_DIR  = 8'h04;
  localparam logic [7:0] ADDR_PORT7_DIR  = 8'h08;
  localparam logic [7:0] ADDR_TIMER_A    = 8'h0C;
  localparam logic [7:0] ADDR_TIMER_B    = 8'h10;
  localparam logic [7:0] ADDR_INFRARED   = 8'h14;
  localparam logic [7:0] ADDR_PULLDOWN   = 8'h18;
  localparam logic [7:0] ADDR_LV_CTRL    = 8'h1C;
  localparam logic [7:0] ADDR_STATUS_E   = 8'h20;
  localparam logic [7:0] ADDR_WDT_CTRL   = 8'h24;
  localparam logic [7:0] ADDR_MODE_CTRL  = 8'h28;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h30;

  // --------------------------------------------------------------
  // reset values and writable masks
  // --------------------------------------------------------------
  localparam logic [7:0] PORT_DIR_POR    = 8'hFF;
  localparam logic [7:0] PORT7_DIR_POR   = 8'h03;
  localparam logic [7:0] PORT7_DIR_MASK  = 8'h03;
  localparam logic [7:0] TIMER_A_MASK    = 8'h04;
  localparam logic [7:0] TIMER_B_MASK    = 8'hC4;
  localparam logic [7:0] PULLDOWN_POR    = 8'hFF;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  localparam logic [7:0] LV_CTRL_POR     = 8'hF3;
  localparam logic [1:0] MODE_POR        = 2'b00;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int LV_IRQ_EN_BIT   = 3;
  localparam int WAKE_EN_BIT     = 0;
  localparam int LV_FLAG_BIT     = 1;
  localparam int WDT_EN_BIT      = 7;
  localparam int GIE_BIT         = 2;
  localparam int IRQ_LVD_BIT     = 0;
  localparam int IRQ_WAKE_BIT    = 1;
  localparam int IRQ_WDT_BIT     = 2;
  localparam int IRQ_LVR_BIT     = 3;
  localparam int IRQ_WIDTH       = 4;

  // --------------------------------------------------------------
  // program addresses
  // --------------------------------------------------------------
  localparam logic [7:0] VECTOR_LVD      = 8'h21;
  localparam logic [7:0] VECTOR_RESET    = 8'h00;

endpackage

// ===== src/lvwrc_evt_if.sv
// decision signals between the control top and the event decoder
`timescale 1ns/1ps
interface lvwrc_evt_if;
  import lvwrc_pkg::*;
  lvwrc_mode_e mode;
  logic        wake_en;
  logic        irq_en;
  logic        gie;
  logic        wdt_en;
  logic        lvd_evt;
  logic        wdt_evt;
  logic        lvr_evt;
  logic        wake;
  logic        set_flag;
  logic        vector;
  logic        do_reset;

  modport ctrl (output mode, wake_en, irq_en, gie, wdt_en, lvd_evt, wdt_evt, lvr_evt,
                input  wake, set_flag, vector, do_reset);
  modport dec  (input  mode, wake_en, irq_en, gie, wdt_en, lvd_evt, wdt_evt, lvr_evt,
                output wake, set_flag, vector, do_reset);
endinterface

// ===== src/lvwrc_sync.sv
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
module lvwrc_sync import lvwrc_pkg::*; #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // pin and clean level
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_q, s2_q, s3_q, out_q;
  logic out_d;

  always_comb begin
    out_d = (s2_q == s3_q) ? s3_q : out_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      out_q <= INIT;
    end else begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign level_out = out_q;

endmodule

// ===== src/lvwrc_decide.sv
// event decoder: wake, flag, vector and reset choice per power mode
`timescale 1ns/1ps
module lvwrc_decide import lvwrc_pkg::*; (
  // decision carrier
  lvwrc_evt_if.dec ev
);

  logic asleep;
  logic lvd_wake;
  logic awake_after;

  always_comb begin
    asleep      = (ev.mode == LVWRC_SLEEP) || (ev.mode == LVWRC_IDLE);
    // wake only with the wake enable
    lvd_wake    = ev.lvd_evt && asleep && ev.wake_en;
    awake_after = !asleep || ev.wake_en;
    // flag only with the interrupt enable
    ev.set_flag = ev.lvd_evt && ev.irq_en;
    // vector only with global enable and core running, or asleep with the wake enable
    ev.vector   = ev.lvd_evt && ev.irq_en && ev.gie && awake_after;
    ev.do_reset = (ev.wdt_evt && ev.wdt_en) || ev.lvr_evt;
    ev.wake     = lvd_wake || (ev.do_reset && asleep);
  end

endmodule

// ===== src/lvwrc_top.sv
// low-voltage wake and reset control with avalon register slave
`timescale 1ns/1ps
module lvwrc_top import lvwrc_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // event pins
  input  wire logic        lvd_detect_in,
  input  wire logic        wdt_timeout_in,
  input  wire logic        lvr_in,
  input  wire logic        ext_reset_n_in,
  // core handshake
  input  wire logic        core_eni_pulse,
  input  wire logic        core_global_irq_disable_instr_pulse,
  output logic             core_wake,
  output logic             core_vector_req,
  output logic             core_reset_req,
  output logic [7:0]       core_target_addr,
  // clock gating
  output logic             osc_run,
  output logic             core_clk_run,
  output logic             periph_run,
  // register outputs
  output logic [7:0]       port5_dir,
  output logic [7:0]       port6_dir,
  output logic [7:0]       port7_dir,
  output logic [7:0]       timer_en_a,
  output logic [7:0]       timer_en_b,
  output logic [7:0]       ir_ctrl,
  output logic [7:0]       port5_pulldown,
  // interrupt
  output logic             irq
);

  // ------------------------------------------------------------
  // pin synchronisers and event edges
  // ------------------------------------------------------------
  logic lvd_lvl, wdt_lvl, lvr_lvl, ext_rst_n_lvl;
  logic lvd_prev_q, wdt_prev_q, lvr_prev_q;

  lvwrc_sync #(.INIT(1'b0)) u_sync_lvd (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_in    (lvd_detect_in),
    .level_out (lvd_lvl)
  );
  lvwrc_sync #(.INIT(1'b0)) u_sync_wdt (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_in    (wdt_timeout_in),
    .level_out (wdt_lvl)
  );
  lvwrc_sync #(.INIT(1'b0)) u_sync_lvr (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_in    (lvr_in),
    .level_out (lvr_lvl)
  );
  lvwrc_sync #(.INIT(1'b1)) u_sync_ext (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_in    (ext_reset_n_in),
    .level_out (ext_rst_n_lvl)
  );

  // ------------------------------------------------------------
  // decoder
  // ------------------------------------------------------------
  lvwrc_evt_if ev ();

  lvwrc_decide u_decide (
    .ev (ev.dec)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  lvwrc_mode_e           mode_q, mode_d;
  logic [7:0]            p5_q, p5_d, p6_q, p6_d, p7_q, p7_d;
  logic [7:0]            ta_q, ta_d, tb_q, tb_d, ir_q, ir_d, pd_q, pd_d;
  logic [7:0]            lvc_q, lvc_d, wdc_q, wdc_d;
  logic                  wake_en_q, wake_en_d, flag_q, flag_d, gie_q, gie_d;
  logic [IRQ_WIDTH-1:0]  ist_q, ist_d, imask_q, imask_d;
  logic                  ack_q, ack_d;
  logic [31:0]           rdata_q, rdata_d;
  logic                  wake_q, wake_d, vec_q, vec_d, rst_q, rst_d;
  logic [7:0]            tgt_q, tgt_d;
  logic                  lvd_evt, wdt_evt, lvr_evt, ext_rst, soft_rst;
  logic                  req, wr_hit;
  logic [7:0]            wb;
  logic [7:0]            rbyte;
  logic [IRQ_WIDTH-1:0]  ievt;

  always_comb begin
    lvd_evt    = lvd_lvl && !lvd_prev_q;
    wdt_evt    = wdt_lvl && !wdt_prev_q;
    lvr_evt    = lvr_lvl && !lvr_prev_q;
    ext_rst    = !ext_rst_n_lvl;
    ev.mode    = mode_q;
    ev.wake_en = wake_en_q;
    ev.irq_en  = lvc_q[LV_IRQ_EN_BIT];
    ev.gie     = gie_q;
    ev.wdt_en  = wdc_q[WDT_EN_BIT];
    ev.lvd_evt = lvd_evt;
    ev.wdt_evt = wdt_evt;
    ev.lvr_evt = lvr_evt;
  end

  // ------------------------------------------------------------
  // bus and register next values
  // ------------------------------------------------------------
  always_comb begin
    req      = avs_read || avs_write;
    wr_hit   = avs_write && ack_q && avs_byteenable[0];
    wb       = avs_writedata[7:0];
    soft_rst = ext_rst || ev.do_reset;
    ack_d    = req && !ack_q;
    p5_d = p5_q; p6_d = p6_q; p7_d = p7_q; ta_d = ta_q; tb_d = tb_q;
    ir_d = ir_q; pd_d = pd_q; lvc_d = lvc_q; wdc_d = wdc_q;
    wake_en_d = wake_en_q;
    imask_d   = imask_q;
    flag_d    = flag_q;
    ist_d     = ist_q;
    case (avs_address)
      ADDR_PORT5_DIR:  rbyte = p5_q;
      ADDR_PORT6_DIR:  rbyte = p6_q;
      ADDR_PORT7_DIR:  rbyte = p7_q;
      ADDR_TIMER_A:    rbyte = ta_q;
      ADDR_TIMER_B:    rbyte = tb_q;
      ADDR_INFRARED:   rbyte = ir_q;
      ADDR_PULLDOWN:   rbyte = pd_q;
      ADDR_LV_CTRL:    rbyte = lvc_q;
      ADDR_STATUS_E:   rbyte = {6'h00, flag_q, wake_en_q};
      ADDR_WDT_CTRL:   rbyte = wdc_q;
      ADDR_MODE_CTRL:  rbyte = {5'h00, gie_q, mode_q};
      ADDR_IRQ_STATUS: rbyte = {4'h0, ist_q};
      ADDR_IRQ_MASK:   rbyte = {4'h0, imask_q};
      default:         rbyte = ZERO_BYTE;
    endcase
    rdata_d = (avs_read && !ack_q) ? {24'h000000, rbyte} : rdata_q;
    if (wr_hit) begin
      case (avs_address)
        ADDR_PORT5_DIR:  p5_d = wb;
        ADDR_PORT6_DIR:  p6_d = wb;
        ADDR_PORT7_DIR:  p7_d = wb & PORT7_DIR_MASK;
        ADDR_TIMER_A:    ta_d = wb & TIMER_A_MASK;
        ADDR_TIMER_B:    tb_d = wb & TIMER_B_MASK;
        ADDR_INFRARED:   ir_d = wb;
        ADDR_PULLDOWN:   pd_d = wb;
        ADDR_LV_CTRL:    lvc_d = wb;
        ADDR_STATUS_E: begin
          wake_en_d = wb[WAKE_EN_BIT];
          if (wb[LV_FLAG_BIT]) begin
            flag_d = 1'b0;
          end
        end
        ADDR_WDT_CTRL:   wdc_d = wb;
        ADDR_IRQ_STATUS: ist_d = ist_q & ~wb[IRQ_WIDTH-1:0];
        ADDR_IRQ_MASK:   imask_d = wb[IRQ_WIDTH-1:0];
        default: begin
        end
      endcase
    end
    // hardware set wins over software clear
    if (ev.set_flag) begin
      flag_d = 1'b1;
    end
    ievt = '0;
    ievt[IRQ_LVD_BIT]  = ev.set_flag;
    ievt[IRQ_WAKE_BIT] = ev.wake;
    ievt[IRQ_WDT_BIT]  = wdt_evt && ev.wdt_en;
    ievt[IRQ_LVR_BIT]  = lvr_evt;
    ist_d = ist_d | ievt;
    // external or watchdog reset keeps port5/6 directions
    if (soft_rst) begin
      p7_d  = PORT7_DIR_POR;
      ta_d  = ZERO_BYTE;
      tb_d  = ZERO_BYTE;
      ir_d  = ZERO_BYTE;
      pd_d  = PULLDOWN_POR;
      lvc_d = lvc_q;
      lvc_d[LV_IRQ_EN_BIT] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // mode machine and core handshake
  // ------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      LVWRC_NORMAL, LVWRC_GREEN: begin
        if (wr_hit && (avs_address == ADDR_MODE_CTRL)) begin
          mode_d = lvwrc_mode_e'(wb[1:0]);
        end
      end
      LVWRC_IDLE, LVWRC_SLEEP: begin
        if (ev.wake) begin
          mode_d = LVWRC_NORMAL;
        end
      end
      default: mode_d = LVWRC_NORMAL;
    endcase
    if (soft_rst) begin
      mode_d = LVWRC_NORMAL;
    end
    gie_d = gie_q;
    if (core_global_irq_disable_instr_pulse) begin
      gie_d = 1'b0;
    end
    if (core_eni_pulse) begin
      gie_d = 1'b1;
    end
    if (ev.vector || soft_rst) begin
      gie_d = 1'b0;
    end
    wake_d = ev.wake;
    vec_d  = ev.vector && !ev.do_reset;
    rst_d  = soft_rst;
    tgt_d  = tgt_q;
    if (soft_rst) begin
      tgt_d = VECTOR_RESET;
    end else if (ev.vector) begin
      tgt_d = VECTOR_LVD;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q     <= LVWRC_NORMAL;
      p5_q       <= PORT_DIR_POR;
      p6_q       <= PORT_DIR_POR;
      p7_q       <= PORT7_DIR_POR;
      ta_q       <= ZERO_BYTE;
      tb_q       <= ZERO_BYTE;
      ir_q       <= ZERO_BYTE;
      pd_q       <= PULLDOWN_POR;
      lvc_q      <= LV_CTRL_POR;
      wdc_q      <= ZERO_BYTE;
      wake_en_q  <= 1'b0;
      flag_q     <= 1'b0;
      gie_q      <= 1'b0;
      ist_q      <= '0;
      imask_q    <= '0;
      ack_q      <= 1'b0;
      rdata_q    <= 32'h00000000;
      wake_q     <= 1'b0;
      vec_q      <= 1'b0;
      rst_q      <= 1'b0;
      tgt_q      <= VECTOR_RESET;
      lvd_prev_q <= 1'b0;
      wdt_prev_q <= 1'b0;
      lvr_prev_q <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      p5_q       <= p5_d;
      p6_q       <= p6_d;
      p7_q       <= p7_d;
      ta_q       <= ta_d;
      tb_q       <= tb_d;
      ir_q       <= ir_d;
      pd_q       <= pd_d;
      lvc_q      <= lvc_d;
      wdc_q      <= wdc_d;
      wake_en_q  <= wake_en_d;
      flag_q     <= flag_d;
      gie_q      <= gie_d;
      ist_q      <= ist_d;
      imask_q    <= imask_d;
      ack_q      <= ack_d;
      rdata_q    <= rdata_d;
      wake_q     <= wake_d;
      vec_q      <= vec_d;
      rst_q      <= rst_d;
      tgt_q      <= tgt_d;
      lvd_prev_q <= lvd_lvl;
      wdt_prev_q <= wdt_lvl;
      lvr_prev_q <= lvr_lvl;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign avs_waitrequest  = req && !ack_q;
  assign avs_readdata     = rdata_q;
  assign core_wake        = wake_q;
  assign core_vector_req  = vec_q;
  assign core_reset_req   = rst_q;
  assign core_target_addr = tgt_q;
  assign osc_run          = (mode_q != LVWRC_SLEEP);
  assign periph_run       = (mode_q != LVWRC_SLEEP);
  assign core_clk_run     = (mode_q == LVWRC_NORMAL) || (mode_q == LVWRC_GREEN);
  assign port5_dir        = p5_q;
  assign port6_dir        = p6_q;
  assign port7_dir        = p7_q;
  assign timer_en_a       = ta_q;
  assign timer_en_b       = tb_q;
  assign ir_ctrl          = ir_q;
  assign port5_pulldown   = pd_q;
  assign irq              = |(ist_q & imask_q);

endmodule

// ===== testbench/lvwrc_checker.sv
// assertion checker for the low-voltage wake and reset control top
`timescale 1ns/1ps
module lvwrc_checker import lvwrc_pkg::*; (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // bus handshake
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // core handshake and gating
  input wire logic       core_wake,
  input wire logic       core_vector_req,
  input wire logic       core_reset_req,
  input wire logic [7:0] core_target_addr,
  input wire logic       osc_run,
  input wire logic       core_clk_run,
  input wire logic       periph_run,
  // register outputs
  input wire logic [7:0] port5_dir,
  input wire logic [7:0] port7_dir,
  input wire logic [7:0] ir_ctrl,
  input wire logic [7:0] port5_pulldown
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_wait_one;
    $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer not after one wait cycle");

  property p_por;
    $rose(reset_n) |-> port5_dir == PORT_DIR_POR && port7_dir == PORT7_DIR_POR
      && ir_ctrl == ZERO_BYTE && port5_pulldown == PULLDOWN_POR;
  endproperty
  a_por: assert property (p_por)
    else $error("power-on register values wrong");

  property p_osc_periph;
    osc_run == periph_run;
  endproperty
  a_osc_periph: assert property (p_osc_periph)
    else $error("timers not gated with oscillator");

  property p_sleep_core;
    !osc_run |-> !core_clk_run;
  endproperty
  a_sleep_core: assert property (p_sleep_core)
    else $error("core clock runs with oscillator stopped");

  property p_vec_target;
    core_vector_req |=> core_target_addr == VECTOR_LVD;
  endproperty
  a_vec_target: assert property (p_vec_target)
    else $error("vector target wrong");

  property p_vec_pulse;
    core_vector_req |=> !core_vector_req;
  endproperty
  a_vec_pulse: assert property (p_vec_pulse)
    else $error("vector request longer than one cycle");

  property p_rst_target;
    core_reset_req |=> core_target_addr == VECTOR_RESET;
  endproperty
  a_rst_target: assert property (p_rst_target)
    else $error("reset target not zero");

  property p_rst_normal;
    core_reset_req |=> core_clk_run && osc_run && !core_vector_req;
  endproperty
  a_rst_normal: assert property (p_rst_normal)
    else $error("reset did not return to running mode");

  property p_wake_run;
    core_wake |=> core_clk_run && osc_run;
  endproperty
  a_wake_run: assert property (p_wake_run)
    else $error("wake left core stopped");
endmodule

bind lvwrc_top lvwrc_checker u_chk (.*);

// ===== testbench/tb_lvwrc_top.sv
// self-checking bench for the low-voltage wake and reset control block
`timescale 1ns/1ps
module tb_lvwrc_top import lvwrc_pkg::*; ;
  logic clk = 1'b0, reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, seed = 32'h5D13CDB7;
  logic lvd_detect_in = 1'b0, wdt_timeout_in = 1'b0, lvr_in = 1'b0, ext_reset_n_in = 1'b1;
  logic core_eni_pulse = 1'b0, core_global_irq_disable_instr_pulse = 1'b0;
  logic core_wake, core_vector_req, core_reset_req, osc_run, core_clk_run, periph_run, irq;
  logic [7:0] core_target_addr, port5_dir, port6_dir, port7_dir;
  logic [7:0] timer_en_a, timer_en_b, ir_ctrl, port5_pulldown;
  logic [7:0] msk [7] = '{8'hFF, 8'hFF, PORT7_DIR_MASK, TIMER_A_MASK, TIMER_B_MASK,
                          8'hFF, 8'hFF};
  int n_fail = 0, checks = 0, n_wake = 0, n_vec = 0, n_rst = 0;

  lvwrc_top dut (.*);

  initial forever #10 clk = ~clk;

  always @(posedge clk) begin
    if (core_wake === 1'b1) n_wake++;
    if (core_vector_req === 1'b1) n_vec++;
    if (core_reset_req === 1'b1) n_rst++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic w;
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      w = avs_waitrequest;
      q = avs_readdata;
      n++;
    end while (w !== 1'b0 && n < 20);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk({31'h0, w}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic evt(input int k);
    @(posedge clk);
    case (k)
      0: lvd_detect_in <= 1'b1;
      1: wdt_timeout_in <= 1'b1;
      default: lvr_in <= 1'b1;
    endcase
    repeat (10) @(posedge clk);
    lvd_detect_in <= 1'b0;
    wdt_timeout_in <= 1'b0;
    lvr_in <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  task automatic set_gie(input logic g);
    @(posedge clk);
    if (g) core_eni_pulse <= 1'b1;
    else core_global_irq_disable_instr_pulse <= 1'b1;
    @(posedge clk);
    core_eni_pulse <= 1'b0;
    core_global_irq_disable_instr_pulse <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial begin
    logic [1:0] m;
    logic we, ie, ge, mk, xw, xv, xf;
    logic [7:0] p6v;
    int w0, v0, r0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    // power-on values and unmapped places
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i), {24'h0, (i < 3 || i == 6) ? msk[i] : 8'h00});
    end
    rd(ADDR_LV_CTRL, {24'h0, LV_CTRL_POR});
    rd(ADDR_MODE_CTRL, 32'h0);
    rd(8'h34, 32'h0);
    rd(8'h01, 32'h0);
    // random writes through writable masks
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      wr(8'(4 * i), {24'h0, seed[7:0]});
      if (i == 1) p6v = seed[7:0];
      rd(8'(4 * i), {24'h0, seed[7:0] & msk[i]});
    end
    avs_byteenable <= 4'h0;
    wr(ADDR_PORT6_DIR, 32'h0);
    avs_byteenable <= 4'hF;
    rd(ADDR_PORT6_DIR, {24'h0, p6v});
    wr(8'h34, 32'hFF);
    rd(8'h34, 32'h0);
    // watchdog reset, disabled then enabled in sleep
    wr(ADDR_PORT5_DIR, 32'h5A);
    wr(ADDR_INFRARED, 32'hA5);
    wr(ADDR_WDT_CTRL, 32'h0);
    r0 = n_rst;
    evt(1);
    chk(n_rst - r0, 0);
    wr(ADDR_WDT_CTRL, 32'h80);
    wr(ADDR_MODE_CTRL, 32'h3);
    @(negedge clk);
    chk(osc_run, 0);
    w0 = n_wake;
    evt(1);
    chk(n_rst - r0, 1);
    chk(n_wake - w0, 1);
    chk(core_target_addr, VECTOR_RESET);
    rd(ADDR_PORT5_DIR, 32'h5A);
    rd(ADDR_INFRARED, 32'h0);
    wr(ADDR_INFRARED, 32'h3C);
    @(posedge clk);
    ext_reset_n_in <= 1'b0;
    repeat (8) @(posedge clk);
    ext_reset_n_in <= 1'b1;
    repeat (6) @(posedge clk);
    rd(ADDR_PORT5_DIR, 32'h5A);
    rd(ADDR_INFRARED, 32'h0);
    // detection in every mode and enable combination
    for (int c = 0; c < 32; c++) begin
      m = c[1:0];
      we = c[2];
      ie = c[3];
      ge = c[4];
      seed = lfsr(seed);
      mk = seed[0];
      r0 = n_rst;
      evt(2);
      chk(n_rst - r0, 1);
      chk(core_target_addr, VECTOR_RESET);
      wr(ADDR_IRQ_STATUS, 32'hF);
      wr(ADDR_STATUS_E, {30'h0, 1'b1, we});
      wr(ADDR_IRQ_MASK, {31'h0, mk});
      wr(ADDR_LV_CTRL, {28'hF, ie, 3'h3});
      set_gie(ge);
      wr(ADDR_MODE_CTRL, {30'h0, m});
      @(negedge clk);
      chk(osc_run, m != 2'b11);
      chk(periph_run, m != 2'b11);
      chk(core_clk_run, m < 2'b10);
      xw = m[1] & we;
      xf = ie;
      xv = ie & ge & (!m[1] | we);
      w0 = n_wake;
      v0 = n_vec;
      evt(0);
      chk(n_wake - w0, xw);
      chk(n_vec - v0, xv);
      if (xv) chk(core_target_addr, VECTOR_LVD);
      rd(ADDR_STATUS_E, {30'h0, xf, we});
      rd(ADDR_MODE_CTRL, {29'h0, ge & !xv, xw ? 2'b00 : m});
      chk(irq, xf & mk);
      wr(ADDR_IRQ_STATUS, 32'h1);
      @(negedge clk);
      chk(irq, 0);
    end
    complete_run();
  end
endmodule
